// File: src/tdm_slot_pkg.sv
// constants for the tdm slot configuration port: register indices,
// reset values, field positions and the fixed slot geometry.
// assumes a 32-bit apb slave with one register per aligned word.
package tdm_slot_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] RX_EDGE_IDX = 6'h07;
   localparam logic [5:0] SENSE_CFG_IDX = 6'h08;
   localparam logic [5:0] RX_SLOT_IDX = 6'h09;
   localparam logic [5:0] TX_FMT_IDX = 6'h0a;
   localparam logic [5:0] V_SLOT_IDX = 6'h0b;
   localparam logic [5:0] I_SLOT_IDX = 6'h0c;
   localparam logic [5:0] B_SLOT_IDX = 6'h0d;
   localparam logic [5:0] T_SLOT_IDX = 6'h0e;
   localparam logic [5:0] G_SLOT_IDX = 6'h0f;
   localparam logic [5:0] STATUS_IDX = 6'h1f;

   // reset values
   localparam logic [7:0] RX_EDGE_RST = 8'h00;
   localparam logic [7:0] SENSE_CFG_RST = 8'h40;
   localparam logic [7:0] RX_SLOT_RST = 8'h10;
   localparam logic [7:0] TX_FMT_RST = 8'h13;
   localparam logic [7:0] V_SLOT_RST = 8'h02;
   localparam logic [7:0] I_SLOT_RST = 8'h00;
   localparam logic [7:0] B_SLOT_RST = 8'h04;
   localparam logic [7:0] T_SLOT_RST = 8'h05;
   localparam logic [7:0] G_SLOT_RST = 8'h06;

   // writable bits; reserved bits read as zero
   localparam logic [7:0] RX_EDGE_MASK = 8'h01;
   localparam logic [7:0] SENSE_CFG_MASK = 8'hc0;
   localparam logic [7:0] FULL_MASK = 8'hff;
   localparam logic [7:0] SLOT_MASK = 8'h7f;

   // field positions
   localparam int RX_RIGHT_HI = 7;
   localparam int RX_RIGHT_LO = 4;
   localparam int RX_LEFT_HI = 3;
   localparam int RX_LEFT_LO = 0;
   localparam int FMT_HALF_BIT = 7;
   localparam int FMT_HOLD_BIT = 6;
   localparam int FMT_KEEP_BIT = 5;
   localparam int FMT_FILL_BIT = 4;
   localparam int FMT_OFS_HI = 3;
   localparam int FMT_OFS_LO = 1;
   localparam int FMT_EDGE_BIT = 0;
   localparam int SEND_EN_BIT = 6;
   localparam int SLOT_HI = 5;
   localparam int SLOT_LO = 0;
   localparam int BAT_LEN_BIT = 7;
   localparam int SENSE_LEN_HI = 7;
   localparam int SENSE_LEN_LO = 6;
   localparam int RX_EDGE_BIT = 0;

   // transmitted quantities, lowest index wins on a slot clash
   localparam int NUM_TX = 5;
   localparam int Q_VOLT = 0;
   localparam int Q_CURR = 1;
   localparam int Q_BAT = 2;
   localparam int Q_TEMP = 3;
   localparam int Q_GAIN = 4;

   // slot geometry: 32 bit clocks per slot, 64 slots per frame
   localparam int POS_W = 11;
   localparam int BIT_W = 5;
   localparam logic [4:0] BIT_MSB = 5'h1f;
   localparam logic [10:0] POS_MAX = 11'h7ff;
   localparam logic [10:0] POS_ONE = 11'h001;
   localparam logic [10:0] RX_OFFSET = 11'h001;
   localparam logic [5:0] LEN8 = 6'h08;
   localparam logic [5:0] LEN16 = 6'h10;

   typedef enum logic [1:0] {
      TX_QUIET = 2'b00,
      TX_DATA = 2'b01,
      TX_KEEP = 2'b11
   } tx_state_e;

endpackage : tdm_slot_pkg

// File: src/tdm_slot_config_port.sv
// tdm slot configuration port: apb registers, receive slot capture and
// transmit slot placement with keeper, fill, offset and launch edge.
// assumes the host drives bit clock and frame sync, frame start on a
// rising frame sync, and sense inputs stable on the system clock.
`timescale 1ns/1ps
`default_nettype none

module tdm_slot_config_port
   import tdm_slot_pkg::*;
(
   input wire logic sys_clk, // system clock, 25 MHz
   input wire logic sys_rst, // asynchronous reset, active high
   input wire logic [7:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic serialBitClock, // bit clock pin
   input wire logic frameSync, // frame sync pin
   input wire logic serialDataIn, // receive data pin
   output logic serialDataOut, // transmit data, output value
   output logic serialDataOutEn, // transmit data, output enable
   input wire logic [31:0] voltageSense, // speaker voltage sample
   input wire logic [31:0] currentSense, // speaker current sample
   input wire logic [15:0] batterySense, // battery voltage sample
   input wire logic [7:0] temperatureSense, // temperature sample
   input wire logic [7:0] gainReduction, // limiter gain reduction
   output logic [31:0] leftSample, // received left word
   output logic [31:0] rightSample, // received right word
   output logic leftValid, // pulse, new left word
   output logic rightValid // pulse, new right word
);

   typedef struct packed {
      logic [2:0] clkSync;
      logic [2:0] fsSync;
      logic [2:0] dinSync;
      logic clkF;
      logic fsF;
      logic dinF;
      logic clkPrev;
      logic fsPrev;
      logic frameSeen;
      logic [10:0] bitPos;
      logic [31:0] rxShift;
      logic [31:0] rxLeft;
      logic [31:0] rxRight;
      logic leftValid;
      logic rightValid;
      logic [7:0] rxEdge;
      logic [7:0] senseCfg;
      logic [7:0] rxSlot;
      logic [7:0] txFmt;
      logic [4:0][7:0] txSlot;
      logic [31:0] snapV;
      logic [31:0] snapI;
      logic [15:0] snapB;
      logic [7:0] snapT;
      logic [7:0] snapG;
      tx_state_e txState;
      logic lsbFlag;
      logic sdoutData;
      logic sdoutOe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

   state_s st;
   state_s next_st;

   default clocking cb_sys @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   function automatic logic [5:0] senseLen(input logic [1:0] code);
      return {1'b0, code, 3'b000} + LEN8;
   endfunction : senseLen

   function automatic logic isMapped(input logic [5:0] idx);
      return (idx >= RX_EDGE_IDX && idx <= G_SLOT_IDX) || idx == STATUS_IDX;
   endfunction : isMapped

   logic rise;
   logic fall;
   logic frameStart;
   logic [10:0] bitAfter;
   logic txFall;
   logic launch;
   logic opp;
   logic [10:0] launchPos;
   logic [10:0] txOfs;
   logic [10:0] txRel;
   logic txInFrame;
   logic rxEv;
   logic [10:0] rxPos;
   logic [10:0] rxRel;
   logic keepOn;
   logic fillHiZ;
   logic [5:0] idx;
   logic [NUM_TX-1:0] hit;
   logic [NUM_TX-1:0] qBit;
   logic [NUM_TX-1:0] qLsb;
   logic [31:0] qWord [NUM_TX];
   logic [5:0] qLen [NUM_TX];
   logic anyHit;

   // filtered pin levels lag the pins by four system clocks
   assign rise = st.clkF & ~st.clkPrev;
   assign fall = ~st.clkF & st.clkPrev;
   assign frameStart = rise & st.fsF & ~st.fsPrev;
   // saturate so an over-long frame never wraps onto slot zero
   assign bitAfter = frameStart ? '0 :
                     (st.bitPos == POS_MAX ? st.bitPos : st.bitPos + POS_ONE);

   assign txFall = st.txFmt[FMT_EDGE_BIT];
   assign launch = txFall ? fall : rise;
   assign opp = txFall ? rise : fall;
   // a rising launch sends the bit that this very edge opens
   assign launchPos = txFall ? st.bitPos : bitAfter;
   assign txOfs = {8'h00, st.txFmt[FMT_OFS_HI:FMT_OFS_LO]};
   assign txInFrame = (st.frameSeen | frameStart) && launchPos >= txOfs;
   assign txRel = launchPos - txOfs;
   assign keepOn = st.txFmt[FMT_KEEP_BIT];
   assign fillHiZ = st.txFmt[FMT_FILL_BIT];

   assign rxEv = st.rxEdge[RX_EDGE_BIT] ? fall : rise;
   assign rxPos = st.rxEdge[RX_EDGE_BIT] ? st.bitPos : bitAfter;
   assign rxRel = rxPos - RX_OFFSET;
   assign idx = paddr[7:2];

   // words are left justified; length picks how many msbs go out
   assign qWord[Q_VOLT] = st.snapV;
   assign qWord[Q_CURR] = st.snapI;
   assign qWord[Q_BAT] = {st.snapB, 16'h0000};
   assign qWord[Q_TEMP] = {st.snapT, 24'h00_0000};
   assign qWord[Q_GAIN] = {st.snapG, 24'h00_0000};
   assign qLen[Q_VOLT] =
      senseLen(st.senseCfg[SENSE_LEN_HI:SENSE_LEN_LO]);
   assign qLen[Q_CURR] =
      senseLen(st.senseCfg[SENSE_LEN_HI:SENSE_LEN_LO]);
   assign qLen[Q_BAT] = st.txSlot[Q_BAT][BAT_LEN_BIT] ? LEN16 : LEN8;
   assign qLen[Q_TEMP] = LEN8;
   assign qLen[Q_GAIN] = LEN8;

   for (genvar q = 0; q < NUM_TX; q++) begin : g_tx
      // enable and slot match per quantity
      assign hit[q] = txInFrame &&
                      st.txSlot[q][SEND_EN_BIT] &&
                      st.txSlot[q][SLOT_HI:SLOT_LO] == txRel[POS_W-1:BIT_W] &&
                      {1'b0, txRel[BIT_W-1:0]} < qLen[q];
      assign qBit[q] = qWord[q][BIT_MSB - txRel[BIT_W-1:0]];
      assign qLsb[q] = {1'b0, txRel[BIT_W-1:0]} == qLen[q] - 6'h01;
   end

   assign anyHit = |hit;

   always_comb begin
      logic selBit;
      logic selLsb;
      logic [7:0] rdByte;
      logic [7:0] wrByte;
      selBit = 1'b0;
      selLsb = 1'b0;
      rdByte = 8'h00;
      wrByte = pwdata[7:0];
      next_st = st;
      next_st.leftValid = 1'b0;
      next_st.rightValid = 1'b0;

      // three-stage synchronisers; a level counts once stages 2 and 3 agree
      next_st.clkSync = {st.clkSync[1:0], serialBitClock};
      next_st.fsSync = {st.fsSync[1:0], frameSync};
      next_st.dinSync = {st.dinSync[1:0], serialDataIn};
      if (st.clkSync[1] == st.clkSync[2]) begin
         next_st.clkF = st.clkSync[2];
      end
      if (st.fsSync[1] == st.fsSync[2]) begin
         next_st.fsF = st.fsSync[2];
      end
      if (st.dinSync[1] == st.dinSync[2]) begin
         next_st.dinF = st.dinSync[2];
      end
      next_st.clkPrev = st.clkF;

      if (rise) begin
         next_st.fsPrev = st.fsF;
         next_st.bitPos = bitAfter;
      end
      // sense words are frozen for the whole frame
      if (frameStart) begin
         next_st.frameSeen = 1'b1;
         next_st.snapV = voltageSense;
         next_st.snapI = currentSense;
         next_st.snapB = batterySense;
         next_st.snapT = temperatureSense;
         next_st.snapG = gainReduction;
      end

      // receive: one shifter serves both channels, msb first
      if (rxEv && st.frameSeen && rxPos >= RX_OFFSET) begin
         next_st.rxShift = {st.rxShift[30:0], st.dinF};
         if (rxRel[BIT_W-1:0] == BIT_MSB) begin
            if (rxRel[POS_W-1:BIT_W] ==
                {2'b00, st.rxSlot[RX_LEFT_HI:RX_LEFT_LO]}) begin
               next_st.rxLeft = {st.rxShift[30:0], st.dinF};
               next_st.leftValid = 1'b1;
            end
            if (rxRel[POS_W-1:BIT_W] ==
                {2'b00, st.rxSlot[RX_RIGHT_HI:RX_RIGHT_LO]}) begin
               next_st.rxRight = {st.rxShift[30:0], st.dinF};
               next_st.rightValid = 1'b1;
            end
         end
      end

      // transmit: lowest quantity index wins a clash the host should avoid
      for (int q = NUM_TX - 1; q >= 0; q--) begin
         if (hit[q]) begin
            selBit = qBit[q];
            selLsb = qLsb[q];
         end
      end
      if (launch) begin
         if (anyHit) begin
            next_st.sdoutData = selBit;
            next_st.sdoutOe = 1'b1;
            next_st.txState = TX_DATA;
            next_st.lsbFlag = selLsb;
         end else if (keepOn && ((st.txState == TX_DATA && st.lsbFlag) ||
                   (st.txState == TX_KEEP && st.txFmt[FMT_HOLD_BIT]))) begin
            next_st.sdoutOe = 1'b1;
            next_st.txState = TX_KEEP;
            next_st.lsbFlag = 1'b0;
         end else begin
            next_st.txState = TX_QUIET;
            next_st.lsbFlag = 1'b0;
            next_st.sdoutData = 1'b0;
            next_st.sdoutOe = st.frameSeen && !fillHiZ;
         end
      end else if (opp && st.txState == TX_DATA && st.lsbFlag &&
                   st.txFmt[FMT_HALF_BIT] && !keepOn) begin
         // half-cycle lsb: end the bit mid-cycle, then release the line or drive zero per fill
         next_st.lsbFlag = 1'b0;
         next_st.txState = TX_QUIET;
         next_st.sdoutData = 1'b0;
         next_st.sdoutOe = !fillHiZ;
      end

      // apb: answer prepared in setup, completes one cycle later
      case (idx)
         RX_EDGE_IDX: rdByte = st.rxEdge;
         SENSE_CFG_IDX: rdByte = st.senseCfg;
         RX_SLOT_IDX: rdByte = st.rxSlot;
         TX_FMT_IDX: rdByte = st.txFmt;
         V_SLOT_IDX: rdByte = st.txSlot[Q_VOLT];
         I_SLOT_IDX: rdByte = st.txSlot[Q_CURR];
         B_SLOT_IDX: rdByte = st.txSlot[Q_BAT];
         T_SLOT_IDX: rdByte = st.txSlot[Q_TEMP];
         G_SLOT_IDX: rdByte = st.txSlot[Q_GAIN];
         STATUS_IDX: rdByte = {st.frameSeen, 1'b0, st.bitPos[POS_W-1:BIT_W]};
         default: rdByte = 8'h00;
      endcase
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      if (psel && !penable) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !isMapped(idx);
         next_st.prdata = {24'h00_0000, rdByte};
      end
      if (psel && penable && st.pready && pwrite && pstrb[0] &&
          isMapped(idx)) begin
         case (idx)
            RX_EDGE_IDX: next_st.rxEdge = wrByte & RX_EDGE_MASK;
            SENSE_CFG_IDX: next_st.senseCfg = wrByte & SENSE_CFG_MASK;
            RX_SLOT_IDX: next_st.rxSlot = wrByte;
            TX_FMT_IDX: next_st.txFmt = wrByte;
            V_SLOT_IDX: next_st.txSlot[Q_VOLT] = wrByte & SLOT_MASK;
            I_SLOT_IDX: next_st.txSlot[Q_CURR] = wrByte & SLOT_MASK;
            B_SLOT_IDX: next_st.txSlot[Q_BAT] = wrByte & FULL_MASK;
            T_SLOT_IDX: next_st.txSlot[Q_TEMP] = wrByte & SLOT_MASK;
            G_SLOT_IDX: next_st.txSlot[Q_GAIN] = wrByte & SLOT_MASK;
            default: next_st.rxEdge = st.rxEdge;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.rxEdge <= RX_EDGE_RST;
         st.senseCfg <= SENSE_CFG_RST;
         st.rxSlot <= RX_SLOT_RST;
         st.txFmt <= TX_FMT_RST;
         st.txSlot <= {G_SLOT_RST, T_SLOT_RST, B_SLOT_RST, I_SLOT_RST,
                       V_SLOT_RST};
         st.txState <= TX_QUIET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign serialDataOut = st.sdoutData;
   assign serialDataOutEn = st.sdoutOe;
   assign leftSample = st.rxLeft;
   assign rightSample = st.rxRight;
   assign leftValid = st.leftValid;
   assign rightValid = st.rightValid;

   AST_RX_SLOT_RST: assert property (
      $fell(sys_rst) |-> st.rxSlot == RX_SLOT_RST)
      else $error("rx slot register wrong after reset");

   AST_TX_FMT_RST: assert property (
      $fell(sys_rst) |-> st.txFmt == TX_FMT_RST && !serialDataOutEn)
      else $error("tx format wrong or line driven after reset");

   AST_QUIET_LINE: assert property (
      launch && !anyHit && fillHiZ && !keepOn |=> !serialDataOutEn)
      else $error("line driven outside enabled slots");

   AST_FILL_ZERO: assert property (
      launch && st.frameSeen && !anyHit && !fillHiZ && !keepOn
      |=> serialDataOutEn && !serialDataOut)
      else $error("unused bit not sent as zero");

   AST_VOLT_BIT: assert property (
      launch && hit[Q_VOLT]
      |=> serialDataOutEn && serialDataOut == $past(qBit[Q_VOLT]))
      else $error("voltage sense bit not sent in its slot");

   AST_LAUNCH_EDGE: assert property (
      $rose(serialDataOutEn) |-> $past(launch) || $past(opp && !fillHiZ))
      else $error("output enabled off the launch edge");

   AST_HALF_LSB: assert property (
      opp && !launch && st.txState == TX_DATA && st.lsbFlag &&
      st.txFmt[FMT_HALF_BIT] && !keepOn && fillHiZ |=> !serialDataOutEn)
      else $error("half-cycle lsb not released");

   AST_KEEP_ONE: assert property (
      launch && keepOn && !st.txFmt[FMT_HOLD_BIT] && st.txState == TX_KEEP &&
      !anyHit && fillHiZ |=> !serialDataOutEn)
      else $error("keeper held past one lsb cycle");

   AST_RX_LEFT: assert property (
      leftValid |-> $past(rxEv) && $past(rxRel[BIT_W-1:0]) == BIT_MSB)
      else $error("left word latched off its last bit");

   AST_SLOT_WRITE: assert property (
      psel && penable && pready && pwrite && pstrb[0] && idx == V_SLOT_IDX
      |=> st.txSlot[Q_VOLT] == ($past(pwdata[7:0]) & SLOT_MASK))
      else $error("voltage slot write lost");

   COV_LEFT: cover property (leftValid);
   COV_KEEP: cover property (st.txState == TX_KEEP && serialDataOutEn);
   COV_VOLT: cover property (launch && hit[Q_VOLT]);

endmodule : tdm_slot_config_port

`default_nettype wire

// File: verif/tdm_host_model.sv
// host end of the tdm link: clocks one frame per go pulse, feeds the
// receive line and records the transmit line for bits 0 to NB-1.
// assumes the block settles its output within one bit clock.
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model #(
   parameter int NB = 288 // bits recorded per frame; the host clocks NB + 1 bit clocks per frame
) (
   input wire logic go, // rise starts a frame
   input wire logic fallLaunch, // block launches on falling edges
   input wire logic [NB-1:0] rxBits, // bit k goes out in bit period k
   input wire logic serial_data_out, // block output value
   input wire logic sdOutEn, // block output enable
   output logic bitClk, // bit clock, idle low between frames
   output logic frame_sync, // frame sync
   output logic sdIn, // receive data to the block
   output logic [NB-1:0] seenVal, // line level for bit k
   output logic [NB-1:0] seenEn, // drive enable for bit k
   output logic busy // frame in progress
);
   logic last = 1'b0;
   wire logic line;
   // no pull on the line: a released line shows the inverse level
   assign line = sdOutEn ? serial_data_out : ~last;
   always @(serial_data_out or sdOutEn) begin
      if (sdOutEn === 1'b1) last = serial_data_out;
   end
   initial begin
      bitClk = 1'b0;
      frame_sync = 1'b0;
      sdIn = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge go);
         busy = 1'b1;
         #7;
         // bit k is read at the launch edge one period later
         for (int n = 0; n < 2 * NB + 2; n++) begin
            if (n % 2 == 0) begin
               #80;
               sdIn = (n / 2 < NB) ? rxBits[n / 2] : ~sdIn;
               frame_sync = (n == 0);
               #80;
            end else begin
               #160;
            end
            bitClk = ~bitClk;
            if (fallLaunch != bitClk && n > 1) begin
               seenVal[n / 2 - 1] = line;
               seenEn[n / 2 - 1] = sdOutEn;
            end
         end
         busy = 1'b0;
      end
   end
endmodule : tdm_host_model
`default_nettype wire

// File: verif/tb_top.sv
// bench for the tdm slot port: apb register checks, then random frames
// clocked by the host model and compared bit by bit.
// assumes a zero-wait apb slave and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tdm_slot_pkg::*;
;
   localparam int NB = 288;
   localparam logic [7:0] RSTV [7:15] = '{RX_EDGE_RST, SENSE_CFG_RST,
      RX_SLOT_RST, TX_FMT_RST, V_SLOT_RST, I_SLOT_RST, B_SLOT_RST,
      T_SLOT_RST, G_SLOT_RST};
   logic sys_clk, sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata, leftS, rightS, gotL, gotR, expL, r;
   logic pready, pslverr, bitClk, frame_sync, sdIn, serial_data_out, sdOutEn, lV, rV;
   logic busy, e, bl, kp = 1'b0, kk = 1'b0, lv = 1'b0, v, hc, kd, eo, ev;
   logic [1:0] h;
   logic [31:0] vS = 32'h0000_0000, iS = 32'h0000_0000;
   logic [15:0] bS = 16'h0000;
   logic [7:0] tS = 8'h00, gS = 8'h00, fmt, lenR, rxSel;
   logic go = 1'b0, fallL = 1'b1;
   logic [NB-1:0] rxBits = '0, seenVal, seenEn;
   logic [31:0] wq [NUM_TX];
   logic [4:0] enR;
   int sl [NUM_TX], lq [NUM_TX];
   int fails = 0, compares = 0, seed = 15, sb;

   tdm_slot_config_port u_tdm_slot_config_port (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialBitClock(bitClk), .frameSync(frame_sync), .serialDataIn(sdIn),
      .serialDataOut(serial_data_out), .serialDataOutEn(sdOutEn),
      .voltageSense(vS), .currentSense(iS), .batterySense(bS),
      .temperatureSense(tS), .gainReduction(gS), .leftSample(leftS),
      .rightSample(rightS), .leftValid(lV), .rightValid(rV)
   );
   tdm_host_model #(.NB(NB)) u_tdm_host_model (
      .go(go), .fallLaunch(fallL), .rxBits(rxBits), .serial_data_out(serial_data_out),
      .sdOutEn(sdOutEn), .bitClk(bitClk), .frame_sync(frame_sync), .sdIn(sdIn),
      .seenVal(seenVal), .seenEn(seenEn), .busy(busy)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (lV === 1'b1) gotL <= leftS;
      if (rV === 1'b1) gotR <= rightS;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic [5:0] idx, input logic wr,
      input logic [7:0] wd, input logic [3:0] st, output logic [31:0] rd,
      output logic err);
      psel <= 1'b1;
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h00_0000, wd};
      pstrb <= st;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic wr(input int i, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(6'(i), 1'b1, d, 4'h1, rd, er);
   endtask : wr

   task automatic rc(input int i, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(6'(i), 1'b0, 8'h00, 4'h0, rd, er);
      chk(rd, {24'h00_0000, d}, "read data");
      chk(32'(er), 32'h0000_0000, "error flag");
   endtask : rc

   // which enabled quantity owns bit k; {hit, lsb}, value in v
   function automatic logic [1:0] data_bit(input int k, output logic bv);
      int p;
      bv = 1'b0;
      p = k - int'(fmt[FMT_OFS_HI:FMT_OFS_LO]);
      for (int q = 0; q < NUM_TX; q++)
         if (enR[q] && p >= 0 && p / 32 == sl[q] && p % 32 < lq[q]) begin
            bv = wq[q][31 - p % 32];
            return {1'b1, p % 32 == lq[q] - 1};
         end
      return 2'b00;
   endfunction : data_bit

   task automatic report_and_stop();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (40000) @(posedge sys_clk);
      fails++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      chk(32'(sdOutEn), 32'h0000_0000, "enable at rest");
      for (int i = 7; i < 11; i++)
         rc(i, RSTV[i]);
      for (int i = 11; i < 16; i++)
         rc(i, RSTV[i]);
      apb(6'h20, 1'b0, 8'h00, 4'h0, r, e);
      chk(r, 32'h0000_0000, "unmapped data");
      chk(32'(e), 32'h0000_0001, "unmapped error");
      apb(RX_SLOT_IDX, 1'b1, 8'h5a, 4'h0, r, e);
      rc(RX_SLOT_IDX, RX_SLOT_RST);
      for (int i = 11; i < 16; i++) begin
         wr(i, 8'hff);
         rc(i, (i == 13) ? FULL_MASK : SLOT_MASK);
      end
      for (int f = 0; f < 6; f++) begin
         fmt = (f == 0) ? TX_FMT_RST : 8'($random(seed));
         enR = (f == 0) ? 5'h00 : 5'($random(seed));
         lenR = 8'($random(seed)) & SENSE_CFG_MASK;
         rxSel = (f == 0) ? RX_SLOT_RST : 8'($random(seed)) & 8'h77;
         bl = 1'($random(seed));
         sb = $random(seed) & 7;
         for (int q = 0; q < NUM_TX; q++) begin
            sl[q] = (sb + q) % 8;
            wq[q] = $random(seed);
            lq[q] = (q < 2) ? 8 * (lenR[7:6] + 1) : 8;
         end
         lq[Q_BAT] = bl ? 16 : 8;
         wq[Q_BAT][15:0] = 16'h0000;
         wq[Q_TEMP][23:0] = 24'h00_0000;
         wq[Q_GAIN][23:0] = 24'h00_0000;
         vS <= wq[Q_VOLT];
         iS <= wq[Q_CURR];
         bS <= wq[Q_BAT][31:16];
         tS <= wq[Q_TEMP][31:24];
         gS <= wq[Q_GAIN][31:24];
         fallL <= fmt[FMT_EDGE_BIT];
         wr(TX_FMT_IDX, fmt);
         wr(SENSE_CFG_IDX, lenR);
         wr(RX_SLOT_IDX, rxSel);
         wr(RX_EDGE_IDX, {7'h00, f[0]});
         for (int q = 0; q < NUM_TX; q++)
            wr(V_SLOT_IDX + q, {q == Q_BAT && bl, enR[q], 6'(sl[q])});
         rc(TX_FMT_IDX, fmt);
         for (int j = 0; j < NB; j += 32) rxBits[j +: 32] = $random(seed);
         for (int j = 0; j < 32; j++) begin
            rxBits[rxSel[3:0] * 32 + 1 + j] = wq[Q_VOLT][31 - j];
            rxBits[rxSel[7:4] * 32 + 1 + j] = wq[Q_CURR][31 - j];
         end
         expL = (rxSel[3:0] == rxSel[7:4]) ? wq[Q_CURR] : wq[Q_VOLT];
         gotL = 'x;
         gotR = 'x;
         go <= 1'b1;
         @(posedge sys_clk);
         go <= 1'b0;
         while (busy !== 1'b0) @(posedge sys_clk);
         // let the last bit clock edge clear the synchronisers first
         repeat (8) @(posedge sys_clk);
         chk(gotL, expL, "left word");
         chk(gotR, wq[Q_CURR], "right word");
         for (int k = 0; k < NB; k++) begin
            h = data_bit(k, v);
            hc = h[0] && fmt[FMT_HALF_BIT] && !fmt[FMT_KEEP_BIT];
            kd = fmt[FMT_KEEP_BIT] && !h[1] &&
                 (kp || (kk && fmt[FMT_HOLD_BIT]));
            eo = kd || !fmt[FMT_FILL_BIT] || (h[1] && !hc);
            ev = kd ? lv : (h[1] && !hc && v);
            chk(32'(seenEn[k]), 32'(eo), "enable");
            chk(32'(seenVal[k] & eo), 32'(ev), "data");
            kp = h[0];
            kk = kd;
            if (h[0]) lv = v;
         end
         // bit NB carries no data but still steps the keeper
         kk = fmt[FMT_KEEP_BIT] && (kp || (kk && fmt[FMT_HOLD_BIT]));
         kp = 1'b0;
      end
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
